// File: design/flash_page_program_sequencer.sv
`timescale 1ns/10ps
// Operation
// - Busy flag high during erase and program
// - Start second machine cycle after 5x,Ax
// - Busy flag drops when operation done
// - Software polls busy from second instruction
// - Boot map bit maps boot flash F800h-FFFFh
// - Latches accept 1 to 128 bytes, any order
// - Page from last loaded latch address
// - Erase then program loaded bytes only
// - Launch with empty latches sets error
// - Latch writes ignored while busy
// - Software loads latches via data pointer only
// - Latch map bit redirects external writes
// - 50h,A0h programs user space
// - 52h,A2h programs extra row
// - 0Ch, write 0000h, 54h,A4h programs fuse
// - Software masks interrupts around launch
// - Launch must match unlock space bits
// - Unlock not followed by launch: error
// - Clear latches after write; clear error
module flash_page_program_sequencer (
    // Core side
    flash_seq_if.device bus,
    // Flash array side
    output logic arrayErase,
    output logic arrayProgram,
    output logic [1:0] arraySpace,
    output logic [8:0] arrayPage,
    output logic [127:0] arrayByteMask,
    output logic [1023:0] arrayData
);
    logic [7:0] latchData [0:flash_seq_pkg::PAGE_BYTES-1];
    logic [127:0] loaded;
    logic [8:0] page;
    logic [1:0] space;
    logic latchMap;
    logic [1:0] launchSpace;
    logic armed;
    logic [1:0] armSpace;
    logic sequence_error_flag;
    logic bootMap;
    logic [15:0] timer;
    flash_seq_pkg::seq_state_type state;
    flash_seq_pkg::seq_state_type next_state;

    wire busy = (state != flash_seq_pkg::IDLE);
    wire [3:0] key = bus.writeData[flash_seq_pkg::KEY_MSB:flash_seq_pkg::KEY_LSB];
    wire [1:0] keySpace = bus.writeData[flash_seq_pkg::SPACE_MSB:flash_seq_pkg::SPACE_LSB];
    wire isUnlock = bus.ctrlWrite && key == flash_seq_pkg::UNLOCK_KEY;
    wire isLaunch = bus.ctrlWrite && key == flash_seq_pkg::LAUNCH_KEY && armed && armSpace == keySpace;
    // Any control write other than a matching launch after unlock breaks the sequence
    wire seqBroken = armed && bus.ctrlWrite && !isLaunch;
    wire clearCmd = isLaunch && keySpace == flash_seq_pkg::SPACE_CLEAR;
    wire progCmd = isLaunch && keySpace != flash_seq_pkg::SPACE_CLEAR && !busy;
    wire emptyLaunch = progCmd && loaded == '0;
    wire goodLaunch = progCmd && loaded != '0;
    wire latchWrite = bus.xdataWrite && latchMap && !busy;
    wire [6:0] col = bus.xdataAddr[flash_seq_pkg::COL_BITS-1:0];
    wire timerDone = timer == 16'h0000;
    wire done = state == flash_seq_pkg::PROGRAM && bus.machineTick && timerDone;

    always_comb begin
        next_state = state;
        unique case (state)
            flash_seq_pkg::IDLE: if (goodLaunch) next_state = flash_seq_pkg::START;
            flash_seq_pkg::START: if (bus.machineTick) next_state = flash_seq_pkg::ERASE;
            flash_seq_pkg::ERASE: if (bus.machineTick && timerDone) next_state = flash_seq_pkg::PROGRAM;
            flash_seq_pkg::PROGRAM: if (bus.machineTick && timerDone) next_state = flash_seq_pkg::IDLE;
        endcase
    end

    always_ff @(posedge bus.clk) begin
        if (bus.rst) begin
            state <= flash_seq_pkg::IDLE;
            timer <= 16'h0000;
        end else begin
            state <= next_state;
            if (next_state == flash_seq_pkg::ERASE && state == flash_seq_pkg::START) begin
                timer <= 16'(flash_seq_pkg::ERASE_CYCLES);
            end else if (next_state == flash_seq_pkg::PROGRAM && state == flash_seq_pkg::ERASE) begin
                timer <= 16'(flash_seq_pkg::PROGRAM_CYCLES);
            end else if (bus.machineTick && !timerDone) begin
                timer <= timer - 16'h0001;
            end
        end
    end

    always_ff @(posedge bus.clk) begin
        if (bus.rst) begin
            latchMap <= 1'b0;
            space <= flash_seq_pkg::SPACE_USER;
            armed <= 1'b0;
            armSpace <= flash_seq_pkg::SPACE_USER;
            launchSpace <= flash_seq_pkg::SPACE_USER;
            sequence_error_flag <= 1'b0;
            bootMap <= 1'b0;
        end else begin
            if (bus.ctrlWrite) begin
                latchMap <= bus.writeData[flash_seq_pkg::LATCH_MAP_BIT];
                space <= keySpace;
                armed <= isUnlock;
                armSpace <= keySpace;
            end
            if (goodLaunch) begin
                launchSpace <= keySpace;
            end
            // Hardware set wins over software clear
            if (seqBroken || emptyLaunch) begin
                sequence_error_flag <= 1'b1;
            end else if (done || (bus.statusWrite && !bus.writeData[flash_seq_pkg::ERROR_FLAG_BIT])) begin
                sequence_error_flag <= 1'b0;
            end
            if (bus.auxWrite) begin
                bootMap <= bus.writeData[flash_seq_pkg::BOOT_MAP_BIT];
            end
        end
    end

    // Latch contents stay frozen from launch to completion
    always_ff @(posedge bus.clk) begin
        if (bus.rst || done || (clearCmd && !busy)) begin
            loaded <= '0;
        end else if (latchWrite) begin
            loaded[col] <= 1'b1;
        end
    end

    always_ff @(posedge bus.clk) begin
        if (bus.rst) begin
            page <= 9'h000;
        end else if (latchWrite) begin
            page <= bus.xdataAddr[15:flash_seq_pkg::COL_BITS];
        end
    end

    always_ff @(posedge bus.clk) begin
        if (latchWrite) begin
            latchData[col] <= bus.writeData;
        end
    end

    always_comb begin
        for (int i = 0; i < flash_seq_pkg::PAGE_BYTES; i++) begin
            arrayData[i*8 +: 8] = latchData[i];
        end
    end

    assign arrayErase = state == flash_seq_pkg::ERASE;
    assign arrayProgram = state == flash_seq_pkg::PROGRAM;
    assign arraySpace = launchSpace;
    assign arrayPage = page;
    assign arrayByteMask = loaded;
    assign bus.controlValue = {4'h0, latchMap, space, busy};
    assign bus.statusValue = {6'h00, loaded != '0, sequence_error_flag};
    assign bus.auxValue = {7'h00, bootMap};
    assign bus.codeBootSel = bootMap && bus.codeAddr >= flash_seq_pkg::BOOT_BASE;
endmodule // flash_page_program_sequencer

// File: design/flash_seq_host.sv
`timescale 1ns/10ps
module flash_seq_host (
    // Wishbone slave
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Code fetch address
    input wire logic [15:0] fetchAddr,
    // Device side
    flash_seq_if.host dev
);
    logic [3:0] divCount;
    logic ack;
    logic [31:0] readData;
    wire req = cyc_i && stb_i && !ack && sel_i[0];
    wire wr = req && we_i;
    wire [7:0] readSel = adr_i == flash_seq_pkg::ADDR_CONTROL ? dev.controlValue :
                         adr_i == flash_seq_pkg::ADDR_STATUS ? dev.statusValue :
                         adr_i == flash_seq_pkg::ADDR_AUX ? dev.auxValue : 8'h00;

    always_ff @(posedge clk) begin
        if (rst || divCount == 4'(flash_seq_pkg::MACHINE_DIV - 1)) begin
            divCount <= 4'h0;
        end else begin
            divCount <= divCount + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
            readData <= 32'h00000000;
        end else begin
            ack <= cyc_i && stb_i && !ack;
            readData <= {24'h000000, readSel};
        end
    end

    assign dev.machineTick = divCount == 4'h0;
    // Latch loads go through the data pointer window only
    assign dev.ctrlWrite = wr && adr_i == flash_seq_pkg::ADDR_CONTROL;
    assign dev.ctrlRead = req && !we_i && adr_i == flash_seq_pkg::ADDR_CONTROL;
    assign dev.statusWrite = wr && adr_i == flash_seq_pkg::ADDR_STATUS;
    assign dev.auxWrite = wr && adr_i == flash_seq_pkg::ADDR_AUX;
    assign dev.xdataWrite = wr && adr_i == flash_seq_pkg::ADDR_LATCH;
    assign dev.xdataAddr = dat_i[23:8];
    assign dev.writeData = dat_i[7:0];
    assign dev.codeAddr = fetchAddr;
    assign ack_o = ack;
    assign dat_o = readData;
endmodule // flash_seq_host

// File: include/flash_seq_if.sv
`timescale 1ns/10ps
interface flash_seq_if (
    input wire logic clk,
    input wire logic rst
);
    logic machineTick;
    logic ctrlWrite;
    logic ctrlRead;
    logic statusWrite;
    logic auxWrite;
    logic xdataWrite;
    logic [15:0] xdataAddr;
    logic [7:0] writeData;
    logic [7:0] controlValue;
    logic [7:0] statusValue;
    logic [7:0] auxValue;
    logic codeBootSel;
    logic [15:0] codeAddr;
    modport device (
        input clk, rst, machineTick, ctrlWrite, ctrlRead, statusWrite, auxWrite, xdataWrite, xdataAddr,
        writeData, codeAddr,
        output controlValue, statusValue, auxValue, codeBootSel
    );
    modport host (
        input clk, rst, controlValue, statusValue, auxValue, codeBootSel,
        output machineTick, ctrlWrite, ctrlRead, statusWrite, auxWrite, xdataWrite, xdataAddr, writeData,
        codeAddr
    );
endinterface

// File: include/flash_seq_pkg.sv
package flash_seq_pkg;
    // Control register fields
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 4;
    localparam int SPACE_MSB = 2;
    localparam int SPACE_LSB = 1;
    localparam int LATCH_MAP_BIT = 3;
    localparam int BUSY_BIT = 0;
    localparam logic [3:0] UNLOCK_KEY = 4'h5;
    localparam logic [3:0] LAUNCH_KEY = 4'hA;
    localparam logic [1:0] SPACE_USER = 2'h0;
    localparam logic [1:0] SPACE_EXTRA = 2'h1;
    localparam logic [1:0] SPACE_FUSE = 2'h2;
    localparam logic [1:0] SPACE_CLEAR = 2'h3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Status register fields
    localparam int ERROR_FLAG_BIT = 0;
    localparam int LOADED_BIT = 1;
    // Aux register
    localparam int BOOT_MAP_BIT = 0;
    // Page geometry
    localparam int PAGE_BYTES = 128;
    localparam int COL_BITS = 7;
    localparam int PAGE_BITS = 9;
    localparam logic [15:0] BOOT_BASE = 16'hF800;
    // Timing: machine cycle divider and programming time
    localparam int CLK_MHZ = 100;
    localparam int MACHINE_DIV = 12;
    localparam int ERASE_TIME_US = 2;
    localparam int PROGRAM_TIME_US = 2;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ / MACHINE_DIV;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ / MACHINE_DIV;
    // Wishbone register offsets (byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_AUX = 4'h8;
    localparam logic [3:0] ADDR_LATCH = 4'hC;
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        START = 2'b01,
        ERASE = 2'b10,
        PROGRAM = 2'b11
    } seq_state_type;
endpackage

// File: testbench/flash_page_program_sequencer_assertions.sv
`timescale 1ns/10ps
module flash_page_program_sequencer_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Interface signals
    input wire logic ctrlWrite,
    input wire logic ctrlRead,
    input wire logic [7:0] writeData,
    input wire logic [15:0] codeAddr,
    input wire logic [7:0] controlValue,
    input wire logic [7:0] statusValue,
    input wire logic [7:0] auxValue,
    input wire logic codeBootSel
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic armed;
    logic [1:0] armedSpace;
    wire logic busy = controlValue[0];
    wire logic match = ctrlWrite && armed && writeData[7:4] == 4'hA && writeData[2:1] == armedSpace;
    wire logic keyed = match && !busy && writeData[2:1] != 2'h3;
    wire logic bootHit = auxValue[0] && codeAddr >= 16'hF800;
    // Any control write between the keys disarms the unlock
    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 1'h0;
            armedSpace <= 2'h0;
        end else if (ctrlWrite) begin
            armed <= writeData[7:4] == 4'h5;
            armedSpace <= writeData[2:1];
        end
    end
    sequence goodLaunch;
        keyed && statusValue[1];
    endsequence
    AST_LAUNCH_BUSY: assert property (goodLaunch |-> ##[1:30] busy) else $error("no busy");
    AST_BUSY_HOLD: assert property ($rose(busy) |-> busy [*8]) else $error("busy short");
    AST_POLL_LATE: assert property ($rose(busy) |-> !ctrlRead) else $error("early poll");
    AST_BUSY_END: assert property ($rose(busy) |-> ##[300:500] $fell(busy)) else $error("busy end");
    AST_EMPTY_ERR: assert property (keyed && !statusValue[1] |-> ##[1:3] statusValue[0]) else $error("empty");
    AST_SEQ_ERR: assert property (ctrlWrite && armed && !match |-> ##[1:3] statusValue[0]) else $error("seq");
    AST_DONE_CLR: assert property ($fell(busy) |-> ##[0:3] statusValue[1:0] == 2'h0) else $error("clr");
    AST_BOOT_ON: assert property (bootHit [*3] |-> codeBootSel) else $error("boot on");
    AST_BOOT_OFF: assert property ((!bootHit) [*3] |-> !codeBootSel) else $error("boot off");
endmodule // flash_page_program_sequencer_assertions

// File: testbench/tb_flash_page_program_sequencer.sv
`timescale 1ns/10ps
module tb_flash_page_program_sequencer;
    logic clk = 1'h0, rst = 1'h1, req = 1'h0, we = 1'h0;
    logic ack, arrayErase, arrayProgram;
    logic [1:0] arraySpace;
    logic [3:0] adr = 4'h0;
    logic [8:0] arrayPage;
    logic [15:0] fetchAddr = 16'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [127:0] arrayByteMask;
    logic [1023:0] arrayData;
    int err_total = 0, checks = 0;
    flash_seq_if fif (.clk(clk), .rst(rst));
    flash_seq_host flash_seq_host_i (.clk(clk), .rst(rst), .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr),
        .sel_i(4'h1), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .fetchAddr(fetchAddr), .dev(fif.host));
    flash_page_program_sequencer flash_page_program_sequencer_i (.bus(fif.device), .arrayErase(arrayErase),
        .arrayProgram(arrayProgram), .arraySpace(arraySpace), .arrayPage(arrayPage),
        .arrayByteMask(arrayByteMask), .arrayData(arrayData));
    flash_page_program_sequencer_assertions asrt_i (.clk(clk), .rst(rst), .ctrlWrite(fif.ctrlWrite),
        .ctrlRead(fif.ctrlRead),
        .writeData(fif.writeData), .codeAddr(fif.codeAddr), .controlValue(fif.controlValue),
        .statusValue(fif.statusValue), .auxValue(fif.auxValue), .codeBootSel(fif.codeBootSel));
    always #5 clk = ~clk;
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 40);
        q = rdat;
        req <= 1'h0;
        @(posedge clk);
        if (n >= 40) err_total++;
    endtask
    task automatic keys(input logic [1:0] su, input logic [1:0] sl);
        wb(1'h1, 4'h0, {24'h0, 4'h5, 1'h0, su, 1'h0});
        wb(1'h1, 4'h0, {24'h0, 4'hA, 1'h0, sl, 1'h0});
    endtask
    // Map, write one latch, unmap again
    task automatic load(input logic [1:0] s, input logic [15:0] a, input logic [7:0] d);
        wb(1'h1, 4'h0, {28'h0, 1'h1, s, 1'h0});
        wb(1'h1, 4'hC, {8'h0, a, d});
        wb(1'h1, 4'h0, 32'h0);
    endtask
    task automatic waitArr(input logic prog);
        int n;
        n = 0;
        while ((prog ? arrayProgram : arrayErase) !== 1'h1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) err_total++;
    endtask
    task automatic bootChk(input logic ax, input logic [15:0] fa, input logic e);
        wb(1'h1, 4'h8, {31'h0, ax});
        wb(1'h0, 4'h8, 32'h0);
        chk(q[0], ax);
        fetchAddr <= fa;
        repeat (4) @(posedge clk);
        chk(fif.codeBootSel, e);
    endtask
    task automatic t_space(input logic [1:0] s, input logic [15:0] la);
        logic [127:0] m;
        int n;
        m = 128'h1 << la[6:0];
        if (s == 2'h0) begin
            load(s, 16'h0105, 8'h11);
            m = m | (128'h1 << 5);
        end
        load(s, la, 8'hC3);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[1], 1'h1);
        keys(s, s);
        waitArr(1'h0);
        chk({arrayErase, arraySpace, arrayPage}, {1'h1, s, la[15:7]});
        chk(arrayByteMask, m);
        chk(arrayData[{la[6:0], 3'h0} +: 8], 8'hC3);
        wb(1'h0, 4'h0, 32'h0);
        chk(q[0], 1'h1);
        load(s, la ^ 16'h1, 8'h77);
        waitArr(1'h1);
        chk({arrayErase, arrayProgram}, 2'h1);
        chk(arrayByteMask, m);
        n = 0;
        do begin
            wb(1'h0, 4'h0, 32'h0);
            n++;
        end while (q[0] !== 1'h0 && n < 200);
        chk(q[0], 1'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[1:0], 2'h0);
        $display("space %0d done", s);
    endtask
    task automatic t_err();
        keys(2'h0, 2'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[1:0], 2'h1);
        wb(1'h1, 4'h4, 32'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[0], 1'h0);
        keys(2'h0, 2'h0);
        wb(1'h1, 4'h4, 32'h0);
        wb(1'h1, 4'h0, 32'h50);
        wb(1'h1, 4'h0, 32'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[0], 1'h1);
        load(2'h0, 16'h0042, 8'h5A);
        keys(2'h1, 2'h0);
        wb(1'h0, 4'h0, 32'h0);
        chk(q[0], 1'h0);
        keys(2'h3, 2'h3);
        wb(1'h0, 4'h4, 32'h0);
        chk(q[1], 1'h0);
        wb(1'h1, 4'h4, 32'h0);
        $display("errors done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        bootChk(1'h1, 16'hF800, 1'h1);
        bootChk(1'h1, 16'hF7FF, 1'h0);
        bootChk(1'h0, 16'hFFFF, 1'h0);
        $display("boot map done");
        t_space(2'h0, 16'h0203);
        t_space(2'h1, 16'hFF85);
        t_space(2'h2, 16'h0000);
        t_err();
        complete_run();
    end
    // Three launches of about 420 cycles each fit well inside this
    initial begin
        #900000;
        err_total++;
        complete_run();
    end
endmodule // tb_flash_page_program_sequencer
